// ---- design/iwd_map.svh ----
// Field positions, encodings and timing counts of the instruction word decoder
`ifndef IWD_MAP_SVH
`define IWD_MAP_SVH

`define IWD_WORD_W        14
`define IWD_FADDR_W       7
`define IWD_FADDR_MAX     7'h7f
`define IWD_DEST_BIT      7
`define IWD_BSEL_LSB      7
`define IWD_BSEL_W        3
`define IWD_LIT8_W        8
`define IWD_LIT11_W       11
`define IWD_OSC_PER_CYC   4
`define IWD_QPH_W         2
`define IWD_CLK_MHZ       100
`define IWD_OSC_MHZ       4
`define IWD_OSC_DIV       (`IWD_CLK_MHZ / `IWD_OSC_MHZ)
`define IWD_OSC_DIV_W     5
`define IWD_SR_C          0
`define IWD_SR_DC         1
`define IWD_SR_Z          2
`define IWD_SR_W          3
`define IWD_W_RST         8'h00
`define IWD_SR_RST        3'h0

`endif

// ---- design/iwd_pkg.sv ----
// Types of the instruction word decoder
package iwd_pkg;

    typedef enum logic [1:0] {
        IWD_GRP_BYTE = 2'h0,
        IWD_GRP_BIT  = 2'h1,
        IWD_GRP_LIT  = 2'h2
    } iwd_grp_e;

    typedef enum logic [4:0] {
        IWD_OP_NOP,   IWD_OP_MOVWF, IWD_OP_CLR,   IWD_OP_SUBWF, IWD_OP_DECF,
        IWD_OP_IORWF, IWD_OP_ANDWF, IWD_OP_XORWF, IWD_OP_ADDWF, IWD_OP_MOVF,
        IWD_OP_COMF,  IWD_OP_INCF,  IWD_OP_DECFSZ, IWD_OP_RRF,  IWD_OP_RLF,
        IWD_OP_SWAPF, IWD_OP_INCFSZ, IWD_OP_BCF,  IWD_OP_BSF,   IWD_OP_BTFSC,
        IWD_OP_BTFSS, IWD_OP_CALL,  IWD_OP_GOTO,  IWD_OP_MOVLW, IWD_OP_RETLW,
        IWD_OP_IORLW, IWD_OP_ANDLW, IWD_OP_XORLW, IWD_OP_SUBLW, IWD_OP_ADDLW,
        IWD_OP_RET,   IWD_OP_MISC
    } iwd_op_e;

    // Quarter-phases of one instruction cycle, Gray order
    typedef enum logic [1:0] {
        IWD_Q1 = 2'b00,
        IWD_Q2 = 2'b01,
        IWD_Q3 = 2'b11,
        IWD_Q4 = 2'b10
    } iwd_qph_e;

endpackage

// ---- design/iwd_field_if.sv ----
// Decoded fields passed from the word splitter to the sequencer
`timescale 1ns/1ps
`default_nettype none
interface iwd_field_if;
    iwd_pkg::iwd_grp_e grp;
    iwd_pkg::iwd_op_e  op;
    logic [6:0]        faddr;
    logic              dest;
    logic [2:0]        bsel;
    logic [7:0]        lit8;
    logic [10:0]       lit11;
    logic              uses_file;
    logic              writes_file;
    logic              chg_flow;
    logic              is_skip;
    logic [2:0]        flag_mask;
    modport src (output grp, op, faddr, dest, bsel, lit8, lit11, uses_file, writes_file,
                 chg_flow, is_skip, flag_mask);
    modport dst (input grp, op, faddr, dest, bsel, lit8, lit11, uses_file, writes_file,
                 chg_flow, is_skip, flag_mask);
endinterface
`default_nettype wire

// ---- design/iwd_split.sv ----
// Combinational splitter of one instruction word into group, operation and fields
`timescale 1ns/1ps
`default_nettype none
`include "iwd_map.svh"
module iwd_split (
    // Instruction word
    input  wire logic [13:0] word,
    // Decoded fields
    iwd_field_if.src         fld
);
    always_comb begin
        fld.faddr = word[6:0];
        fld.dest  = word[`IWD_DEST_BIT];
        fld.bsel  = word[`IWD_BSEL_LSB +: `IWD_BSEL_W];
        fld.lit8  = word[7:0];
        fld.lit11 = word[10:0];
        fld.grp   = iwd_pkg::IWD_GRP_LIT;
        fld.op    = iwd_pkg::IWD_OP_MISC;
        fld.chg_flow  = 1'b0;
        fld.is_skip   = 1'b0;
        fld.flag_mask = 3'h0;
        // Top two bits pick the group, except return and misc words under 00, which go to the literal group; x bits never looked at
        case (word[13:12])
            2'b00: begin
                fld.grp = iwd_pkg::IWD_GRP_BYTE;
                case (word[11:8])
                    4'h0: begin
                        if (word[7]) begin
                            fld.op = iwd_pkg::IWD_OP_MOVWF;
                        end else if (word[6:0] == 7'h08) begin
                            fld.op = iwd_pkg::IWD_OP_RET;
                            fld.grp = iwd_pkg::IWD_GRP_LIT;
                            fld.chg_flow = 1'b1;
                        end else if (word[6:0] == 7'h09) begin
                            fld.op = iwd_pkg::IWD_OP_RET;
                            fld.grp = iwd_pkg::IWD_GRP_LIT;
                            fld.chg_flow = 1'b1;
                        end else if (word[6:0] == 7'h63 || word[6:0] == 7'h64) begin
                            fld.op = iwd_pkg::IWD_OP_MISC;
                            fld.grp = iwd_pkg::IWD_GRP_LIT;
                        end else begin
                            fld.op = iwd_pkg::IWD_OP_NOP;
                        end
                    end
                    4'h1: begin
                        fld.op = iwd_pkg::IWD_OP_CLR;
                        fld.flag_mask = 3'b100;
                    end
                    4'h2: begin
                        fld.op = iwd_pkg::IWD_OP_SUBWF;
                        fld.flag_mask = 3'b111;
                    end
                    4'h3: begin
                        fld.op = iwd_pkg::IWD_OP_DECF;
                        fld.flag_mask = 3'b100;
                    end
                    4'h4: begin
                        fld.op = iwd_pkg::IWD_OP_IORWF;
                        fld.flag_mask = 3'b100;
                    end
                    4'h5: begin
                        fld.op = iwd_pkg::IWD_OP_ANDWF;
                        fld.flag_mask = 3'b100;
                    end
                    4'h6: begin
                        fld.op = iwd_pkg::IWD_OP_XORWF;
                        fld.flag_mask = 3'b100;
                    end
                    4'h7: begin
                        fld.op = iwd_pkg::IWD_OP_ADDWF;
                        fld.flag_mask = 3'b111;
                    end
                    4'h8: begin
                        fld.op = iwd_pkg::IWD_OP_MOVF;
                        fld.flag_mask = 3'b100;
                    end
                    4'h9: begin
                        fld.op = iwd_pkg::IWD_OP_COMF;
                        fld.flag_mask = 3'b100;
                    end
                    4'ha: begin
                        fld.op = iwd_pkg::IWD_OP_INCF;
                        fld.flag_mask = 3'b100;
                    end
                    4'hb: begin
                        fld.op = iwd_pkg::IWD_OP_DECFSZ;
                        fld.is_skip = 1'b1;
                    end
                    4'hc: begin
                        fld.op = iwd_pkg::IWD_OP_RRF;
                        fld.flag_mask = 3'b001;
                    end
                    4'hd: begin
                        fld.op = iwd_pkg::IWD_OP_RLF;
                        fld.flag_mask = 3'b001;
                    end
                    4'he: begin
                        fld.op = iwd_pkg::IWD_OP_SWAPF;
                    end
                    default: begin
                        fld.op = iwd_pkg::IWD_OP_INCFSZ;
                        fld.is_skip = 1'b1;
                    end
                endcase
            end
            2'b01: begin
                fld.grp = iwd_pkg::IWD_GRP_BIT;
                case (word[11:10])
                    2'b00:   fld.op = iwd_pkg::IWD_OP_BCF;
                    2'b01:   fld.op = iwd_pkg::IWD_OP_BSF;
                    2'b10: begin
                        fld.op = iwd_pkg::IWD_OP_BTFSC;
                        fld.is_skip = 1'b1;
                    end
                    default: begin
                        fld.op = iwd_pkg::IWD_OP_BTFSS;
                        fld.is_skip = 1'b1;
                    end
                endcase
            end
            2'b10: begin
                fld.op = word[11] ? iwd_pkg::IWD_OP_GOTO : iwd_pkg::IWD_OP_CALL;
                fld.chg_flow = 1'b1;
            end
            default: begin
                case (word[11:8])
                    4'h0, 4'h1, 4'h2, 4'h3: fld.op = iwd_pkg::IWD_OP_MOVLW;
                    4'h4, 4'h5, 4'h6, 4'h7: begin
                        fld.op = iwd_pkg::IWD_OP_RETLW;
                        fld.chg_flow = 1'b1;
                    end
                    4'h8: begin
                        fld.op = iwd_pkg::IWD_OP_IORLW;
                        fld.flag_mask = 3'b100;
                    end
                    4'h9: begin
                        fld.op = iwd_pkg::IWD_OP_ANDLW;
                        fld.flag_mask = 3'b100;
                    end
                    4'ha: begin
                        fld.op = iwd_pkg::IWD_OP_XORLW;
                        fld.flag_mask = 3'b100;
                    end
                    4'hc, 4'hd: begin
                        fld.op = iwd_pkg::IWD_OP_SUBLW;
                        fld.flag_mask = 3'b111;
                    end
                    4'he, 4'hf: begin
                        fld.op = iwd_pkg::IWD_OP_ADDLW;
                        fld.flag_mask = 3'b111;
                    end
                    default: fld.op = iwd_pkg::IWD_OP_NOP;
                endcase
            end
        endcase
        fld.uses_file   = (fld.grp != iwd_pkg::IWD_GRP_LIT) && (fld.op != iwd_pkg::IWD_OP_NOP);
        fld.writes_file = (fld.op == iwd_pkg::IWD_OP_MOVWF) || (fld.op == iwd_pkg::IWD_OP_BCF)
                       || (fld.op == iwd_pkg::IWD_OP_BSF)
                       || ((fld.grp == iwd_pkg::IWD_GRP_BYTE) && fld.dest
                           && (fld.op != iwd_pkg::IWD_OP_NOP));
    end
endmodule
`default_nettype wire

// ---- design/iwd_core.sv ----
// Instruction word decoder and execution sequencer of the accumulator core
`timescale 1ns/1ps
`default_nettype none
`include "iwd_map.svh"
module iwd_core #(
    parameter int OSC_DIV = `IWD_OSC_DIV
) (
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        nrst,
    // Program memory
    input  wire logic [13:0] instr_word,
    output logic             fetch_stb,
    // File register port
    input  wire logic [7:0]  file_rdata,
    input  wire logic        file_is_port,
    input  wire logic [7:0]  port_pin_level,
    output logic [6:0]       file_addr,
    output logic             file_rd,
    output logic             file_wr,
    output logic [7:0]       file_wdata,
    // Program flow
    output logic             flow_load,
    output logic [10:0]      flow_target,
    output logic             flow_call,
    output logic             flow_return,
    // State
    output logic [7:0]       work_q,
    output logic [2:0]       status_q,
    output logic             bubble_q
);
    // Divider counter is five bits wide, so larger ratios cannot be served
    if (OSC_DIV < 1 || OSC_DIV > 31) begin : g_bad_div
        $error("OSC_DIV out of range");
    end

    // ********************
    // Oscillator divider and quarter phases
    // ********************
    logic [`IWD_OSC_DIV_W-1:0] div_q;
    logic                      osc_en;
    iwd_pkg::iwd_qph_e         qph_q;

    assign osc_en = (div_q == 5'(OSC_DIV - 1));

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            div_q <= '0;
        end else if (osc_en) begin
            div_q <= '0;
        end else begin
            div_q <= div_q + 5'h1;
        end
    end

    // Four oscillator periods per instruction cycle
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            qph_q <= iwd_pkg::IWD_Q1;
        end else if (osc_en) begin
            case (qph_q)
                iwd_pkg::IWD_Q1: qph_q <= iwd_pkg::IWD_Q2;
                iwd_pkg::IWD_Q2: qph_q <= iwd_pkg::IWD_Q3;
                iwd_pkg::IWD_Q3: qph_q <= iwd_pkg::IWD_Q4;
                default:         qph_q <= iwd_pkg::IWD_Q1;
            endcase
        end
    end

    logic q1_end;
    logic q2_end;
    logic q4_end;
    assign q1_end = osc_en && (qph_q == iwd_pkg::IWD_Q1);
    assign q2_end = osc_en && (qph_q == iwd_pkg::IWD_Q2);
    assign q4_end = osc_en && (qph_q == iwd_pkg::IWD_Q4);

    // ********************
    // Instruction latch and decode
    // ********************
    logic [13:0] ir_q;
    iwd_field_if fld ();

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            ir_q <= 14'h0000;
        end else if (q4_end) begin
            ir_q <= instr_word;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            fetch_stb <= 1'b0;
        end else begin
            fetch_stb <= q4_end;
        end
    end

    iwd_split u_split (
        .word (ir_q),
        .fld  (fld)
    );

    // ********************
    // Read-modify-write datapath
    // ********************
    logic [7:0] rd_val_q;
    logic [7:0] operand;
    logic [7:0] result;
    logic [2:0] flags_new;
    logic       skip_take;
    logic [8:0] sum;
    logic [4:0] nib;
    logic [7:0] bmask;

    // Read even when only writing
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            rd_val_q <= 8'h00;
        end else if (q2_end && fld.uses_file) begin
            rd_val_q <= file_is_port ? port_pin_level : file_rdata;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            file_rd <= 1'b0;
        end else begin
            file_rd <= q1_end && fld.uses_file && !bubble_q;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            file_addr <= 7'h00;
        end else begin
            file_addr <= fld.faddr;
        end
    end

    always_comb begin
        operand = (fld.grp == iwd_pkg::IWD_GRP_LIT) ? fld.lit8 : rd_val_q;
        bmask   = 8'h01 << fld.bsel;
        sum     = 9'h000;
        nib     = 5'h00;
        result  = operand;
        flags_new = status_q;
        case (fld.op)
            iwd_pkg::IWD_OP_ADDWF, iwd_pkg::IWD_OP_ADDLW: begin
                sum = {1'b0, operand} + {1'b0, work_q};
                nib = {1'b0, operand[3:0]} + {1'b0, work_q[3:0]};
                result = sum[7:0];
            end
            iwd_pkg::IWD_OP_SUBWF, iwd_pkg::IWD_OP_SUBLW: begin
                sum = {1'b0, operand} + {1'b0, ~work_q} + 9'h001;
                nib = {1'b0, operand[3:0]} + {1'b0, ~work_q[3:0]} + 5'h01;
                result = sum[7:0];
            end
            iwd_pkg::IWD_OP_CLR:    result = 8'h00;
            iwd_pkg::IWD_OP_MOVWF:  result = work_q;
            iwd_pkg::IWD_OP_ANDWF, iwd_pkg::IWD_OP_ANDLW: result = operand & work_q;
            iwd_pkg::IWD_OP_IORWF, iwd_pkg::IWD_OP_IORLW: result = operand | work_q;
            iwd_pkg::IWD_OP_XORWF, iwd_pkg::IWD_OP_XORLW: result = operand ^ work_q;
            iwd_pkg::IWD_OP_COMF:   result = ~operand;
            iwd_pkg::IWD_OP_INCF, iwd_pkg::IWD_OP_INCFSZ: result = operand + 8'h01;
            iwd_pkg::IWD_OP_DECF, iwd_pkg::IWD_OP_DECFSZ: result = operand - 8'h01;
            iwd_pkg::IWD_OP_RLF: begin
                result = {operand[6:0], status_q[`IWD_SR_C]};
                sum    = {operand[7], 8'h00};
            end
            iwd_pkg::IWD_OP_RRF: begin
                result = {status_q[`IWD_SR_C], operand[7:1]};
                sum    = {operand[0], 8'h00};
            end
            iwd_pkg::IWD_OP_SWAPF:  result = {operand[3:0], operand[7:4]};
            iwd_pkg::IWD_OP_BCF:    result = operand & ~bmask;
            iwd_pkg::IWD_OP_BSF:    result = operand | bmask;
            default:                result = operand;
        endcase
        // Only masked flags move
        if (fld.flag_mask[`IWD_SR_C]) begin
            flags_new[`IWD_SR_C] = sum[8];
        end
        if (fld.flag_mask[`IWD_SR_DC]) begin
            flags_new[`IWD_SR_DC] = nib[4];
        end
        if (fld.flag_mask[`IWD_SR_Z]) begin
            flags_new[`IWD_SR_Z] = (result == 8'h00);
        end
        case (fld.op)
            iwd_pkg::IWD_OP_BTFSC:  skip_take = !(|(operand & bmask));
            iwd_pkg::IWD_OP_BTFSS:  skip_take = |(operand & bmask);
            iwd_pkg::IWD_OP_INCFSZ, iwd_pkg::IWD_OP_DECFSZ: skip_take = (result == 8'h00);
            default:                skip_take = 1'b0;
        endcase
    end

    // ********************
    // Write-back and sequencing
    // ********************
    // Bubble cycle commits nothing, so a skipped word leaves no trace
    logic commit;
    assign commit = q4_end && !bubble_q;

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            file_wr <= 1'b0;
        end else begin
            file_wr <= commit && fld.writes_file;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            file_wdata <= 8'h00;
        end else begin
            file_wdata <= result;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            work_q <= `IWD_W_RST;
        end else if (commit) begin
            if ((fld.grp == iwd_pkg::IWD_GRP_BYTE) && !fld.dest
                && fld.op != iwd_pkg::IWD_OP_MOVWF && fld.op != iwd_pkg::IWD_OP_NOP) begin
                work_q <= result;
            end else if (fld.op == iwd_pkg::IWD_OP_MOVLW || fld.op == iwd_pkg::IWD_OP_RETLW
                         || ((fld.grp == iwd_pkg::IWD_GRP_LIT) && (|fld.flag_mask))) begin
                work_q <= result;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            status_q <= `IWD_SR_RST;
        end else if (commit) begin
            status_q <= flags_new;
        end
    end

    // Second cycle of a skip or jump runs as a no-operation
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            bubble_q <= 1'b0;
        end else if (q4_end) begin
            bubble_q <= !bubble_q && (fld.chg_flow || (fld.is_skip && skip_take));
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            flow_load <= 1'b0;
        end else begin
            flow_load <= commit && (fld.op == iwd_pkg::IWD_OP_GOTO
                                    || fld.op == iwd_pkg::IWD_OP_CALL);
        end
    end

    // Target follows the literal every cycle; only the strobes qualify it
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            flow_target <= 11'h000;
        end else begin
            flow_target <= fld.lit11;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            flow_call <= 1'b0;
        end else begin
            flow_call <= commit && (fld.op == iwd_pkg::IWD_OP_CALL);
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            flow_return <= 1'b0;
        end else begin
            flow_return <= commit && (fld.op == iwd_pkg::IWD_OP_RET
                                      || fld.op == iwd_pkg::IWD_OP_RETLW);
        end
    end

endmodule
`default_nettype wire

// ---- test/iwd_pmem.sv ----
// Program memory model handing one instruction word per fetch
`timescale 1ns/1ps
`default_nettype none
module iwd_pmem (
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        nrst,
    // Fetch side
    input  wire logic        fetch_stb,
    input  wire logic [13:0] next_word,
    output logic [13:0]      instr_word
);
    // Word moves on only once the core has taken it, always whole
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            instr_word <= 14'h0000;
        end else if (fetch_stb) begin
            instr_word <= next_word;
        end
    end
endmodule
`default_nettype wire

// ---- test/iwd_core_properties.sv ----
// Port assertions of the instruction word decoder
`timescale 1ns/1ps
`default_nettype none
module iwd_core_properties #(
    parameter int OSC_DIV = 25
) (
    // Clock and reset
    input wire logic       clk_sys,
    input wire logic       nrst,
    // Watched outputs
    input wire logic       fetch_stb,
    input wire logic       file_rd,
    input wire logic       file_wr,
    input wire logic       flow_load,
    input wire logic       flow_call,
    input wire logic       bubble_q,
    input wire logic [7:0] work_q,
    input wire logic [2:0] status_q
);
    // ****************
    // Checks
    // ****************
    localparam int CYC = 4 * OSC_DIV;
    localparam int RDW = 3 * OSC_DIV;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    fetch_period_a: assert property (fetch_stb |-> ##CYC fetch_stb)
        else $error("fetch strobe period wrong");
    fetch_pulse_a: assert property (fetch_stb |=> !fetch_stb [*3])
        else $error("fetch strobe longer than one cycle");
    write_commit_a: assert property (file_wr |-> fetch_stb)
        else $error("file write outside commit cycle");
    read_first_a: assert property (file_wr |-> $past(file_rd, RDW))
        else $error("file write without earlier read");
    call_loads_a: assert property (flow_call |-> flow_load)
        else $error("call without flow load");
    load_bubble_a: assert property (flow_load |-> ##[0:1] bubble_q)
        else $error("flow change without bubble");
    // First bubble cycle still carries the write of the word that caused it
    bubble_idle_a: assert property (bubble_q |-> !file_rd
        && (!file_wr || $rose(bubble_q)))
        else $error("file access in bubble cycle");
    bubble_commit_a: assert property ($fell(bubble_q) |-> !file_wr && !flow_load)
        else $error("bubbled word committed");
    work_commit_a: assert property (!$stable(work_q) |-> fetch_stb)
        else $error("working register changed off commit");
    status_commit_a: assert property (!$stable(status_q) |-> fetch_stb)
        else $error("status changed off commit");
endmodule
bind iwd_core iwd_core_properties #(.OSC_DIV(OSC_DIV)) u_chk (
    .clk_sys(clk_sys), .nrst(nrst), .fetch_stb(fetch_stb), .file_rd(file_rd),
    .file_wr(file_wr), .flow_load(flow_load), .flow_call(flow_call),
    .bubble_q(bubble_q), .work_q(work_q), .status_q(status_q)
);
`default_nettype wire

// ---- test/tb_instruction_word_decoder.sv ----
// Self-checking bench of the instruction word decoder
`timescale 1ns/1ps
`default_nettype none
module tb_instruction_word_decoder;
    logic        clk_sys = 1'b0, nrst = 1'b0, file_is_port = 1'b0;
    logic [13:0] next_word = 14'h0000, instr_word;
    logic [7:0]  file_rdata = 8'h0f, port_pin_level = 8'h00, file_wdata, work_q;
    logic        fetch_stb, file_rd, file_wr, flow_load, flow_call, flow_return, bubble_q;
    logic [6:0]  file_addr;
    logic [10:0] flow_target;
    logic [2:0]  status_q;
    logic        rd_seen = 1'b0, bub_seen = 1'b0;
    int          error_cnt = 0, checks = 0, cyc = 0;
    always #5 clk_sys = ~clk_sys;
    iwd_pmem u_pmem (.clk_sys(clk_sys), .nrst(nrst), .fetch_stb(fetch_stb),
        .next_word(next_word), .instr_word(instr_word));
    iwd_core #(.OSC_DIV(1)) dut (.clk_sys(clk_sys), .nrst(nrst), .instr_word(instr_word),
        .fetch_stb(fetch_stb), .file_rdata(file_rdata), .file_is_port(file_is_port),
        .port_pin_level(port_pin_level), .file_addr(file_addr), .file_rd(file_rd),
        .file_wr(file_wr), .file_wdata(file_wdata), .flow_load(flow_load),
        .flow_target(flow_target), .flow_call(flow_call), .flow_return(flow_return),
        .work_q(work_q), .status_q(status_q), .bubble_q(bubble_q));
    // ****************
    // Support tasks
    // ****************
    task wrap_up;
        if (error_cnt == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // Pulses sampled mid-cycle, where all outputs are settled
    always @(negedge clk_sys) begin
        cyc++;
        if (file_rd === 1'b1) rd_seen = 1'b1;
        if (bubble_q === 1'b1) bub_seen = 1'b1;
        if (cyc == 3000) begin
            error_cnt++;
            wrap_up();
        end
    end
    task chk(input logic [10:0] got, input logic [10:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Returns at the edge closing a fetch cycle; outputs read there are pre-edge values
    task wait_fetch;
        int n;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (fetch_stb !== 1'b1 && n < 40);
        if (fetch_stb !== 1'b1) begin
            error_cnt++;
            wrap_up();
        end
    endtask
    // Entered at a fetch edge; a padding no-op follows w, returns at the fetch edge one cycle after the commit edge of w
    task run(input logic [13:0] w);
        next_word <= w;
        bub_seen = 1'b0;
        wait_fetch();
        next_word <= 14'h0000;
        wait_fetch();
        rd_seen = 1'b0;
        wait_fetch();
    endtask
    // ****************
    // Scenarios
    // ****************
    task t_literal;
        run(14'h335a);
        chk(work_q, 8'h5a);
        chk(status_q, 3'h0);
        chk(file_wr, 1'b0);
    endtask
    task t_byte;
        run(14'h077f);
        chk(work_q, 8'h69);
        chk(status_q, 3'h2);
        chk(file_addr, 7'h7f);
        chk(file_wr, 1'b0);
        run(14'h07ff);
        chk(file_wr, 1'b1);
        chk(file_wdata, 8'h78);
        chk(work_q, 8'h69);
        run(14'h01a0);
        chk(rd_seen, 1'b1);
        chk(file_wdata, 8'h00);
        chk(status_q, 3'h6);
    endtask
    task t_skip;
        run(14'h1985);
        run(14'h0000);
        chk(bub_seen, 1'b0);
        run(14'h1d85);
        chk(rd_seen, 1'b1);
        chk(status_q, 3'h6);
        run(14'h0000);
        chk(bub_seen, 1'b1);
    endtask
    task t_flow;
        run(14'h2923);
        chk(flow_load, 1'b1);
        chk(flow_target, 11'h123);
        run(14'h0000);
        chk(bub_seen, 1'b1);
        run(14'h2456);
        chk(flow_call, 1'b1);
        chk(flow_load, 1'b1);
        chk(flow_target, 11'h456);
        run(14'h3777);
        chk(bub_seen, 1'b1);
        chk(flow_return, 1'b1);
        chk(flow_call, 1'b0);
        chk(work_q, 8'h77);
    endtask
    // Latch differs from pins, so a wrong read source shows
    task t_port;
        file_is_port <= 1'b1;
        port_pin_level <= 8'hc3;
        file_rdata <= 8'h3c;
        run(14'h0886);
        chk(file_wdata, 8'hc3);
        chk(status_q, 3'h2);
        chk(work_q, 8'h77);
    endtask
    initial begin
        repeat (8) @(posedge clk_sys);
        nrst <= 1'b1;
        wait_fetch();
        t_literal();
        t_byte();
        t_skip();
        t_flow();
        t_port();
        wrap_up();
    end
endmodule
`default_nettype wire
